// ### shared/tcc_pkg.sv
// Package: register map, fields, codes and counts of the 16-bit timer
// Functional notes
// - Filter output changes after four equal samples
// - Filter adds four clocks of capture delay
// - Edge select: zero falling, one rising
// - Capture copies count and sets capture flag
// - Capture off when capture value is TOP
// - Clock select: stop, div 1/8/64/256/1024, external
// - External pin counts even when driven as output
// - Force strobes act only in non-PWM modes
// - Force applies match action to channel output
// - Force raises no flag, never clears counter
// - Force bits always read zero
// - One shared temporary high byte for words
// - Counter write blocks next compare match
// - Compare registers compared with counter continuously
// - Capture source is pin or comparator
// - Capture value writable by software
// - Capture request when enabled and global set
// - Compare-B request when enabled and global set
// - Non-PWM output: off, toggle, clear, set
// - Compare flag set after match, not forced
// - Capture and compare flags clear by vector or write one, overflow by write one
package tcc_pkg;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;
   // Register indices, byte address is four times the index
   localparam logic [5:0] IDX_FLAGS = 6'h0b;
   localparam logic [5:0] IDX_MASK = 6'h0c;
   localparam logic [5:0] IDX_FORCE = 6'h22;
   localparam logic [5:0] IDX_ICR_L = 6'h24;
   localparam logic [5:0] IDX_ICR_H = 6'h25;
   localparam logic [5:0] IDX_OCRB_L = 6'h28;
   localparam logic [5:0] IDX_OCRB_H = 6'h29;
   localparam logic [5:0] IDX_OCRA_L = 6'h2a;
   localparam logic [5:0] IDX_OCRA_H = 6'h2b;
   localparam logic [5:0] IDX_CNT_L = 6'h2c;
   localparam logic [5:0] IDX_CNT_H = 6'h2d;
   localparam logic [5:0] IDX_CTLB = 6'h2e;
   localparam logic [5:0] IDX_CTLA = 6'h2f;
   localparam logic [5:0] IDX_CSRC = 6'h30;
   // Field positions
   localparam int CTLB_NOISE = 7;
   localparam int CTLB_EDGE = 6;
   localparam int CTLB_WGMH = 3;
   localparam int CTLB_CS = 0;
   localparam int CTLA_COMA = 6;
   localparam int CTLA_COMB = 4;
   localparam int CTLA_WGML = 0;
   localparam int FOC_A = 7;
   localparam int FOC_B = 6;
   localparam int FLG_CAP = 5;
   localparam int FLG_CMPB = 2;
   localparam int FLG_CMPA = 1;
   localparam int FLG_OVF = 0;
   localparam int MSK_CAP = 5;
   localparam int MSK_CMPB = 2;
   localparam int CSRC_ACOMP = 0;
   // Writable bit masks and reset values
   localparam logic [7:0] CTLA_WMASK = 8'hf3;
   localparam logic [7:0] CTLB_WMASK = 8'hdf;
   localparam logic [7:0] FLAG_MASK = 8'h27;
   localparam logic [7:0] CSRC_WMASK = 8'h01;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   // Clock source codes and prescaler tap widths
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int DIV8_BITS = 3;
   localparam int DIV64_BITS = 6;
   localparam int DIV256_BITS = 8;
   localparam int DIV1024_BITS = 10;
   localparam int FILT_LEN = 4;
   // Waveform modes, fixed TOP values, output actions
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_CTC_A = 4'h4;
   localparam logic [3:0] WGM_CTC_I = 4'hc;
   localparam logic [15:0] TOP_8 = 16'h00ff;
   localparam logic [15:0] TOP_9 = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   localparam logic [15:0] TOP_MAX = 16'hffff;
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOG = 2'h1;
   localparam logic [1:0] COM_CLR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
endpackage : tcc_pkg

// ### shared/tcc_evt_if.sv
// Event interface between the timer core and its input stages
interface tcc_evt_if;
   logic tick; // Timer clock pulse
   logic cap_evt; // Qualified capture event
   modport tick_src (output tick);
   modport cap_src (output cap_evt);
   modport core (input tick, input cap_evt);
endinterface : tcc_evt_if

// ### logic/tcc_clk_sel.sv
// Counting clock selection from prescaler taps or external pin edges
module tcc_clk_sel #(
   parameter int PRE_W = 10 // Prescaler width
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic ce, // Clock enable
   input wire logic [2:0] cs, // Clock source select
   input wire logic ext_pin, // External count pin
   tcc_evt_if.tick_src evt // Tick out
);
   import tcc_pkg::*;
   logic [PRE_W-1:0] pre_r;
   logic ext_s_r, ext_p_r, sel;

   // True on the last clock of a 2**n period
   function automatic logic tap(input logic [PRE_W-1:0] p, input int n);
      logic [PRE_W-1:0] m;
      m = PRE_W'((1 << n) - 1);
      tap = (p & m) == m;
   endfunction : tap

   // Free-running prescaler, so a first count may come early
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_r <= '0;
      else if (ce)
         pre_r <= pre_r + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_s_r <= 1'b0;
         ext_p_r <= 1'b0;
      end
      else if (ce)
      begin
         ext_s_r <= ext_pin;
         ext_p_r <= ext_s_r;
      end
   end

   always_comb
   begin
      unique case (cs)
         CS_STOP: sel = 1'b0;
         CS_DIV1: sel = 1'b1;
         CS_DIV8: sel = tap(pre_r, DIV8_BITS);
         CS_DIV64: sel = tap(pre_r, DIV64_BITS);
         CS_DIV256: sel = tap(pre_r, DIV256_BITS);
         CS_DIV1024: sel = tap(pre_r, DIV1024_BITS);
         CS_EXT_FALL: sel = ext_p_r && !ext_s_r;
         CS_EXT_RISE: sel = ext_s_r && !ext_p_r;
      endcase
   end
   assign evt.tick = ce && sel;

   chk_div8_gap: assert property (@(posedge pclk) disable iff (!presetn)
      cs == CS_DIV8 && evt.tick |=> (!evt.tick || cs != CS_DIV8) [*7])
      else $error("div 8 tick too early");
endmodule : tcc_clk_sel

// ### logic/tcc_cap_cond.sv
// Capture input source select, noise filter and edge detection
module tcc_cap_cond #(
   parameter int FLEN = tcc_pkg::FILT_LEN // Filter sample count
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic ce, // Clock enable
   input wire logic pin, // Capture pin
   input wire logic acomp, // Comparator output
   input wire logic acomp_sel, // Use comparator as source
   input wire logic noise_en, // Filter enable
   input wire logic rise_sel, // One rising, zero falling
   input wire logic enable, // Capture allowed
   tcc_evt_if.cap_src evt // Event out
);
   import tcc_pkg::*;
   logic src, lvl, raw_r, filt_r, prev_r;
   logic [FLEN-1:0] hist_r;

   assign src = acomp_sel ? acomp : pin;

   // Sample history; filtered level moves on a full run of equals
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         raw_r <= 1'b0;
         hist_r <= '0;
         filt_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else if (ce)
      begin
         raw_r <= src;
         hist_r <= {hist_r[FLEN-2:0], src};
         if (&hist_r)
            filt_r <= 1'b1;
         else if (~|hist_r)
            filt_r <= 1'b0;
         prev_r <= lvl;
      end
   end

   // filtered path is four clocks behind
   assign lvl = noise_en ? filt_r : raw_r;
   assign evt.cap_evt = ce && enable && lvl != prev_r && lvl == rise_sel;

   chk_filt_hold: assert property (@(posedge pclk) disable iff (!presetn)
      ce && noise_en && hist_r != '0 && hist_r != '1 |=> $stable(filt_r))
      else $error("filter moved on mixed samples");
endmodule : tcc_cap_cond

// ### logic/tcc_timer16.sv
// Top of the 16-bit timer: APB registers, counter, compare, capture
//
// Design decision made here: the APB register port.
module tcc_timer16 (
   input wire logic pclk, // Clock, 10 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic ce, // Clock enable, freezes all state
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [tcc_pkg::DATA_W-1:0] pwdata, // APB write data
   output logic [tcc_pkg::DATA_W-1:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic capture_input_pin, // Capture pin
   input wire logic comparator_out, // Comparator result
   input wire logic external_count_pin, // External count pin
   input wire logic global_irq_enable, // Global interrupt flag
   input wire logic capture_vector_ack, // Capture vector taken
   input wire logic compare_a_vector_ack, // Compare A vector taken
   input wire logic compare_b_vector_ack, // Compare B vector taken
   output logic capture_irq, // Capture request
   output logic compare_b_irq, // Compare B request
   output logic waveform_out_a, // Channel A level
   output logic waveform_out_a_en, // Channel A owns pin
   output logic waveform_out_b, // Channel B level
   output logic waveform_out_b_en // Channel B owns pin
);
   import tcc_pkg::*;

   tcc_evt_if evt ();

   logic [7:0] ctla_r, ctlb_r, mask_r, flags_r, temp_r, csrc_r;
   logic [15:0] cnt_r, ocra_r, ocrb_r, icr_r, top;
   logic [7:0] rd_nxt, hi_nxt, hisnap_r, wd, flg_set, flg_clr;
   logic [5:0] idx;
   logic [3:0] wgm;
   logic err_nxt, setup, wr_en, rd_en, np, at_top, bot;
   logic blk_r, cnt_wr, mat_a, mat_b, foc_a, foc_b;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Normal and both clear-on-compare modes
   function automatic logic non_pwm(input logic [3:0] m);
      non_pwm = (m == WGM_NORMAL) || (m == WGM_CTC_A) || (m == WGM_CTC_I);
   endfunction : non_pwm

   // Modes whose TOP is the capture value
   function automatic logic icr_top(input logic [3:0] m);
      icr_top = m[3] && !m[0];
   endfunction : icr_top

   // High bytes of the word registers
   function automatic logic is_hi(input logic [5:0] i);
      is_hi = i == IDX_ICR_H || i == IDX_CNT_H || i == IDX_OCRA_H || i == IDX_OCRB_H;
   endfunction : is_hi

   // Low bytes of the word registers
   function automatic logic is_lo(input logic [5:0] i);
      is_lo = i == IDX_ICR_L || i == IDX_CNT_L || i == IDX_OCRA_L || i == IDX_OCRB_L;
   endfunction : is_lo

   // Next output level after a match or a pass through BOTTOM
   function automatic logic wave_nxt(input logic cur, input logic [1:0] com,
      input logic npwm, input logic hit, input logic bottom);
      wave_nxt = cur;
      if (npwm && hit)
      begin
         unique case (com)
            COM_OFF: wave_nxt = cur;
            COM_TOG: wave_nxt = !cur;
            COM_CLR: wave_nxt = 1'b0;
            COM_SET: wave_nxt = 1'b1;
         endcase
      end
      else if (!npwm && (com == COM_CLR || com == COM_SET))
      begin
         if (hit)
            wave_nxt = (com == COM_SET);
         else if (bottom)
            wave_nxt = (com == COM_CLR);
      end
   endfunction : wave_nxt

   // Input stages
   tcc_clk_sel u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .cs(ctlb_r[CTLB_CS+2:CTLB_CS]),
      .ext_pin(external_count_pin),
      .evt(evt.tick_src)
   );

   // capture disabled while capture value is TOP
   tcc_cap_cond u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .pin(capture_input_pin),
      .acomp(comparator_out),
      .acomp_sel(csrc_r[CSRC_ACOMP]),
      .noise_en(ctlb_r[CTLB_NOISE]),
      .rise_sel(ctlb_r[CTLB_EDGE]),
      .enable(!icr_top(wgm)),
      .evt(evt.cap_src)
   );

   // Mode decode; phase-correct modes count up only here
   assign wgm = {ctlb_r[CTLB_WGMH+1:CTLB_WGMH], ctla_r[CTLA_WGML+1:CTLA_WGML]};
   assign np = non_pwm(wgm);

   // TOP value per mode
   always_comb
   begin
      if (icr_top(wgm))
         top = icr_r;
      else if (wgm == WGM_CTC_A || (wgm[3] && wgm[0]))
         top = ocra_r;
      else
      begin
         unique case (wgm[1:0])
            2'h0: top = TOP_MAX;
            2'h1: top = TOP_8;
            2'h2: top = TOP_9;
            2'h3: top = TOP_10;
         endcase
      end
   end
   assign at_top = cnt_r == top;
   assign bot = evt.tick && at_top;

   // APB phases; zero wait states while enabled
   assign pready = ce;
   assign idx = paddr[IDX_W+1:2];
   assign setup = ce && psel && !penable;
   assign wr_en = ce && psel && penable && pwrite && !pslverr;
   assign rd_en = ce && psel && penable && !pwrite && !pslverr;
   assign wd = pwdata[7:0];

   // Read decode; unmapped or unaligned addresses answer an error
   always_comb
   begin
      rd_nxt = 8'h00;
      hi_nxt = temp_r;
      err_nxt = paddr[1:0] != 2'h0;
      unique case (idx)
         IDX_FLAGS: rd_nxt = flags_r;
         IDX_MASK: rd_nxt = mask_r;
         IDX_CTLA: rd_nxt = ctla_r;
         IDX_CTLB: rd_nxt = ctlb_r;
         IDX_CSRC: rd_nxt = csrc_r;
         IDX_FORCE: rd_nxt = 8'h00;
         IDX_ICR_L:
         begin
            rd_nxt = icr_r[7:0];
            hi_nxt = icr_r[15:8];
         end
         IDX_CNT_L:
         begin
            rd_nxt = cnt_r[7:0];
            hi_nxt = cnt_r[15:8];
         end
         IDX_OCRA_L:
         begin
            rd_nxt = ocra_r[7:0];
            hi_nxt = ocra_r[15:8];
         end
         IDX_OCRB_L:
         begin
            rd_nxt = ocrb_r[7:0];
            hi_nxt = ocrb_r[15:8];
         end
         IDX_ICR_H, IDX_CNT_H, IDX_OCRA_H, IDX_OCRB_H: rd_nxt = temp_r;
         default: err_nxt = 1'b1;
      endcase
   end

   // Answer sampled in setup so both bytes come from one snapshot
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
         pslverr <= 1'b0;
         hisnap_r <= RST_BYTE;
      end
      else if (setup)
      begin
         prdata <= {24'h000000, rd_nxt};
         pslverr <= err_nxt;
         hisnap_r <= hi_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctla_r <= RST_BYTE;
         ctlb_r <= RST_BYTE;
         mask_r <= RST_BYTE;
         csrc_r <= RST_BYTE;
      end
      else if (wr_en)
      begin
         if (idx == IDX_CTLA)
            ctla_r <= wd & CTLA_WMASK;
         if (idx == IDX_CTLB)
            ctlb_r <= wd & CTLB_WMASK;
         if (idx == IDX_MASK)
            mask_r <= wd & FLAG_MASK;
         if (idx == IDX_CSRC)
            csrc_r <= wd & CSRC_WMASK;
      end
   end

   // one temporary byte for all words
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         temp_r <= RST_BYTE;
      else if (wr_en && is_hi(idx))
         temp_r <= wd;
      else if (rd_en && is_lo(idx))
         temp_r <= hisnap_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ocra_r <= RST_WORD;
         ocrb_r <= RST_WORD;
      end
      else if (wr_en)
      begin
         if (idx == IDX_OCRA_L)
            ocra_r <= {temp_r, wd};
         if (idx == IDX_OCRB_L)
            ocrb_r <= {temp_r, wd};
      end
   end

   // Counter; a software write beats a tick in the same cycle
   assign cnt_wr = wr_en && idx == IDX_CNT_L;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= RST_WORD;
      else if (cnt_wr)
         cnt_r <= {temp_r, wd};
      // only the count itself clears at TOP
      else if (evt.tick)
         cnt_r <= at_top ? RST_WORD : cnt_r + 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         blk_r <= 1'b0;
      else if (cnt_wr)
         blk_r <= 1'b1;
      else if (evt.tick)
         blk_r <= 1'b0;
   end

   assign mat_a = evt.tick && !blk_r && cnt_r == ocra_r;
   assign mat_b = evt.tick && !blk_r && cnt_r == ocrb_r;
   assign foc_a = wr_en && idx == IDX_FORCE && wd[FOC_A] && np;
   assign foc_b = wr_en && idx == IDX_FORCE && wd[FOC_B] && np;

   // Capture value: a hardware capture wins over a software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         icr_r <= RST_WORD;
      else if (evt.cap_evt)
         icr_r <= cnt_r;
      else if (wr_en && idx == IDX_ICR_L)
         icr_r <= {temp_r, wd};
   end

   // Flag sources and clears; sets win over clears
   always_comb
   begin
      flg_set = 8'h00;
      flg_clr = 8'h00;
      // compare flags set at the tick ending the match cycle, capture flag on its event
      flg_set[FLG_CAP] = evt.cap_evt || (icr_top(wgm) && bot);
      flg_set[FLG_CMPB] = mat_b;
      flg_set[FLG_CMPA] = mat_a;
      flg_set[FLG_OVF] = bot;
      if (wr_en && idx == IDX_FLAGS)
         flg_clr = wd;
      flg_clr[FLG_CAP] = flg_clr[FLG_CAP] || (ce && capture_vector_ack);
      flg_clr[FLG_CMPA] = flg_clr[FLG_CMPA] || (ce && compare_a_vector_ack);
      flg_clr[FLG_CMPB] = flg_clr[FLG_CMPB] || (ce && compare_b_vector_ack);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_r <= RST_BYTE;
      else if (ce)
         flags_r <= ((flags_r & ~flg_clr) | flg_set) & FLAG_MASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         waveform_out_a <= 1'b0;
         waveform_out_b <= 1'b0;
      end
      else if (ce)
      begin
         waveform_out_a <= wave_nxt(waveform_out_a, ctla_r[CTLA_COMA+1:CTLA_COMA], np,
            mat_a || foc_a, bot);
         waveform_out_b <= wave_nxt(waveform_out_b, ctla_r[CTLA_COMB+1:CTLA_COMB], np,
            mat_b || foc_b, bot);
      end
   end
   assign waveform_out_a_en = ctla_r[CTLA_COMA+1:CTLA_COMA] != COM_OFF;
   assign waveform_out_b_en = ctla_r[CTLA_COMB+1:CTLA_COMB] != COM_OFF;

   assign capture_irq = global_irq_enable && mask_r[MSK_CAP] && flags_r[FLG_CAP];
   assign compare_b_irq = global_irq_enable && mask_r[MSK_CMPB] && flags_r[FLG_CMPB];

   // Checks beside the logic
   chk_force_readzero: assert property (
      rd_en && idx == IDX_FORCE |-> prdata == '0)
      else $error("force register read nonzero");
   chk_cnt_block: assert property (
      cnt_wr ##1 (evt.tick && !cnt_wr) |-> !mat_a && !mat_b)
      else $error("match after counter write");
   chk_cmpb_flag: assert property (
      mat_b |=> flags_r[FLG_CMPB])
      else $error("compare B flag not set");
   chk_force_noflag: assert property (
      foc_b && !mat_b && !flags_r[FLG_CMPB] |=> !flags_r[FLG_CMPB])
      else $error("force set compare flag");
   chk_force_toggle: assert property (
      foc_a && !mat_a && ctla_r[CTLA_COMA+1:CTLA_COMA] == COM_TOG
      |=> waveform_out_a != $past(waveform_out_a))
      else $error("forced toggle missing");
   chk_pwm_noforce: assert property (
      wr_en && idx == IDX_FORCE && !np && !mat_a && !bot |=> $stable(waveform_out_a))
      else $error("force acted in PWM mode");
   chk_capture_copy: assert property (
      evt.cap_evt |=> icr_r == $past(cnt_r) && flags_r[FLG_CAP])
      else $error("capture not stored");
   chk_icr_top_off: assert property (
      icr_top(wgm) |-> !evt.cap_evt)
      else $error("capture while capture is TOP");
   chk_ocra_commit: assert property (
      wr_en && idx == IDX_OCRA_L |=> ocra_r == {$past(temp_r), $past(wd)})
      else $error("compare A commit wrong");
   chk_lo_latch: assert property (
      rd_en && idx == IDX_CNT_L |=> temp_r == $past(hisnap_r))
      else $error("high byte not latched");
   chk_cap_irq: assert property (
      (evt.cap_evt && mask_r[MSK_CAP] && !capture_vector_ack)
      ##1 (global_irq_enable && mask_r[MSK_CAP]) |-> capture_irq)
      else $error("capture request missing");
   chk_cmpb_irq: assert property (
      (mat_b && mask_r[MSK_CMPB] && !compare_b_vector_ack)
      ##1 (global_irq_enable && mask_r[MSK_CMPB]) |-> compare_b_irq)
      else $error("compare B request missing");
   chk_vec_clear: assert property (
      ce && capture_vector_ack && !flg_set[FLG_CAP] |=> !flags_r[FLG_CAP])
      else $error("vector did not clear flag");

   cov_capture: cover property (evt.cap_evt ##1 capture_irq);
   cov_force: cover property (foc_a ##1 waveform_out_a_en);
   cov_wrap: cover property (bot && !np);
endmodule : tcc_timer16

// ### verification/tcc_timer16_test.sv
// Self-checking bench for the 16-bit timer with capture and compare
module tcc_timer16_test;
   timeunit 1ns;
   timeprecision 1ns;
   import tcc_pkg::*;
   typedef struct {logic [5:0] idx; logic w; logic [7:0] v;} tcc_row_s;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic cap_pin = 1'h0, gie = 1'h0, cap_ack = 1'h0, err;
   logic pready, pslverr, cap_irq, b_irq, wa, wa_en, wb, wb_en;
   logic [7:0] paddr = 8'h00;
   logic [7:0] rd;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [7:0] ctla[6] = '{8'h50, 8'h50, 8'hf0, 8'ha0, 8'hf1, 8'h00};
   logic [7:0] outs[6] = '{8'h0f, 8'h0a, 8'h0f, 8'h0a, 8'h0a, 8'h00};
   int num_errors = 0;
   int n_tests = 0;
   // Reset values, masks, read-zero strobes and paired byte access
   // control writes keep the reserved bit zero
   tcc_row_s rows[14] = '{'{IDX_MASK, 1'h0, RST_BYTE}, '{IDX_CTLB, 1'h0, RST_BYTE},
      '{IDX_ICR_L, 1'h0, RST_BYTE}, '{IDX_ICR_H, 1'h0, RST_BYTE}, '{IDX_MASK, 1'h1, 8'hff},
      '{IDX_MASK, 1'h0, FLAG_MASK}, '{IDX_FORCE, 1'h1, 8'hc0}, '{IDX_FORCE, 1'h0, 8'h00},
      '{IDX_ICR_H, 1'h1, 8'h12}, '{IDX_ICR_L, 1'h1, 8'h34}, '{IDX_ICR_L, 1'h0, 8'h34},
      '{IDX_ICR_H, 1'h0, 8'h12}, '{IDX_CTLB, 1'h1, CTLB_WMASK}, '{IDX_CTLB, 1'h0, CTLB_WMASK}};

   tcc_timer16 u_tcc_timer16 (
      .pclk(pclk),
      .presetn(presetn),
      .ce(1'h1),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .capture_input_pin(cap_pin),
      .comparator_out(1'h0),
      .external_count_pin(1'h0),
      .global_irq_enable(gie),
      .capture_vector_ack(cap_ack),
      .compare_a_vector_ack(1'h0),
      .compare_b_vector_ack(1'h0),
      .capture_irq(cap_irq),
      .compare_b_irq(b_irq),
      .waveform_out_a(wa),
      .waveform_out_a_en(wa_en),
      .waveform_out_b(wb),
      .waveform_out_b_en(wb_en)
   );

   // 100 ns period
   always #50 pclk = ~pclk;

   // One APB transfer; an idle edge first keeps strobes from toggling twice
   task automatic apb(input logic [5:0] idx, input logic w, input logic [7:0] d);
      @(posedge pclk);
      paddr <= {idx, 2'h0};
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'h1;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("tests=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   initial
   begin
      int k;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[i])
      begin
         apb(rows[i].idx, rows[i].w, rows[i].v);
         if (!rows[i].w)
            chk(rd, rows[i].v); // Row value
      end
      apb(6'h3f, 1'h0, 8'h00);
      chk({7'h0, err}, 8'h01); // Unmapped index refused
      $display("register rows done");
      // Count from zero at full rate up to compare B
      apb(IDX_CTLB, 1'h1, 8'h00);
      apb(IDX_OCRB_H, 1'h1, 8'h00);
      apb(IDX_OCRB_L, 1'h1, 8'h20);
      apb(IDX_CNT_H, 1'h1, 8'h00);
      apb(IDX_CNT_L, 1'h1, 8'h00);
      apb(IDX_FLAGS, 1'h1, FLAG_MASK);
      gie <= 1'h1;
      apb(IDX_CTLB, 1'h1, {5'h0, CS_DIV1});
      for (k = 0; k < 80 && b_irq !== 1'h1; k++)
         @(posedge pclk);
      chk({7'h0, k >= 30 && k <= 36}, 8'h01); // Match timing
      apb(IDX_CTLB, 1'h1, 8'h00);
      gie <= 1'h0;
      @(posedge pclk);
      @(posedge pclk);
      chk({7'h0, b_irq}, 8'h00); // Global gate
      gie <= 1'h1;
      apb(IDX_FLAGS, 1'h1, 8'h04);
      @(posedge pclk);
      chk({7'h0, b_irq}, 8'h00); // Write one clears
      $display("compare test done");
      // Frozen count makes the captured value known
      apb(IDX_CNT_H, 1'h1, 8'h0a);
      apb(IDX_CNT_L, 1'h1, 8'hbc);
      apb(IDX_CTLB, 1'h1, 8'h40);
      cap_pin <= 1'h1;
      repeat (4) @(posedge pclk);
      chk({7'h0, cap_irq}, 8'h01); // Capture request
      apb(IDX_ICR_L, 1'h0, 8'h00);
      chk(rd, 8'hbc); // Low byte
      apb(IDX_ICR_H, 1'h0, 8'h00);
      chk(rd, 8'h0a); // High byte
      cap_ack <= 1'h1;
      @(posedge pclk);
      cap_ack <= 1'h0;
      @(posedge pclk);
      chk({7'h0, cap_irq}, 8'h00); // Vector clears
      cap_pin <= 1'h0;
      repeat (4) @(posedge pclk);
      chk({7'h0, cap_irq}, 8'h00); // Wrong edge
      // Filter: short pulse ignored, long one captured late
      apb(IDX_CTLB, 1'h1, 8'hc0);
      cap_pin <= 1'h1;
      repeat (2) @(posedge pclk);
      cap_pin <= 1'h0;
      repeat (8) @(posedge pclk);
      chk({7'h0, cap_irq}, 8'h00); // Glitch dropped
      cap_pin <= 1'h1;
      repeat (4) @(posedge pclk);
      chk({7'h0, cap_irq}, 8'h00); // Still delayed
      repeat (3) @(posedge pclk);
      chk({7'h0, cap_irq}, 8'h01); // Filtered capture
      $display("capture test done");
      // Forced match through toggle, set and clear, then in PWM, then with output off
      apb(IDX_CTLB, 1'h1, 8'h00);
      apb(IDX_FLAGS, 1'h1, FLAG_MASK);
      foreach (ctla[i])
      begin
         apb(IDX_CTLA, 1'h1, ctla[i]);
         apb(IDX_FORCE, 1'h1, 8'hc0);
         @(posedge pclk);
         chk({4'h0, wb_en, wb, wa_en, wa}, outs[i]); // Pin level
      end
      apb(IDX_FLAGS, 1'h0, 8'h00);
      chk(rd, 8'h00); // No flag from force
      $display("force test done");
      close_out();
   end

   // Run needs under a thousand cycles; this bound catches a hang
   initial
   begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      close_out();
   end
endmodule : tcc_timer16_test
